// *** rtl/wooc_option_config.sv ***
// Option configuration package and write-once option register bank

// ****************************************************************
// Package
// ****************************************************************
package wooc_pkg;
  // Register byte addresses
  localparam logic [31:0] WOOC_SYS_OFS = 32'h0000_0000;
  localparam logic [31:0] WOOC_DEV_OFS = 32'h0000_0004;

  // System option register fields
  localparam int unsigned WOOC_SYS_WDOG_DIS  = 0;
  localparam int unsigned WOOC_SYS_STOP_EN   = 1;
  localparam int unsigned WOOC_SYS_WDOG_SHRT = 2;
  localparam int unsigned WOOC_SYS_SHORT_REC = 3;
  localparam int unsigned WOOC_SYS_LVD_PWR   = 4;
  localparam int unsigned WOOC_SYS_LVD_RST   = 5;
  localparam int unsigned WOOC_SYS_LVD_STOP  = 6;

  // Device option register fields
  localparam int unsigned WOOC_DEV_CAN_DIS = 0;
  localparam int unsigned WOOC_DEV_EE_CLK  = 1;
  localparam int unsigned WOOC_DEV_EMU     = 2;
  localparam int unsigned WOOC_DEV_VERSION = 7;

  // Values after reset
  localparam logic [6:0] WOOC_SYS_RST = 7'h00;
  localparam logic [1:0] WOOC_DEV_RST = 2'h0;
  localparam logic       WOOC_EMU_RST = 1'b0;

  // Counts of cycles
  localparam int unsigned WOOC_LVD_PERSIST    = 9;
  localparam logic [12:0] WOOC_STOP_REC_SHORT = 13'h0020;
  localparam logic [12:0] WOOC_STOP_REC_LONG  = 13'h1000;
  localparam logic [17:0] WOOC_WDOG_SHORT     = 18'h01ff0;
  localparam logic [17:0] WOOC_WDOG_LONG      = 18'h3fff0;

  // Address decode results
  localparam logic [1:0] WOOC_SEL_NONE = 2'h0;
  localparam logic [1:0] WOOC_SEL_SYS  = 2'h1;
  localparam logic [1:0] WOOC_SEL_DEV  = 2'h2;

  typedef enum logic [1:0] {
    WOOC_LVD_IDLE  = 2'b00,
    WOOC_LVD_COUNT = 2'b01,
    WOOC_LVD_HELD  = 2'b11
  } wooc_lvd_state_t;

  typedef struct packed {
    logic [6:0]  sys;
    logic [1:0]  dev;
    logic        sys_lock;
    logic        dev_lock;
    logic        err;
    logic [31:0] rdata;
  } wooc_regs_t;

  localparam wooc_regs_t WOOC_REGS_RST = '{
    sys:      WOOC_SYS_RST,
    dev:      WOOC_DEV_RST,
    sys_lock: 1'b0,
    dev_lock: 1'b0,
    err:      1'b0,
    rdata:    32'h0000_0000
  };
endpackage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Option register bank
// ****************************************************************
module wooc_option_config #(
  parameter int unsigned ADDR_W       = 12,
  // Version bit default is an arbitrary value
  parameter logic        VERSION_BIT  = 1'b1,
  parameter logic [17:0] WDOG_SHORT   = wooc_pkg::WOOC_WDOG_SHORT,
  parameter logic [17:0] WDOG_LONG    = wooc_pkg::WOOC_WDOG_LONG
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              por_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stop_mode,
  input  wire logic              low_supply_trip,
  input  wire logic              supply_recovered_trip,
  output logic                   detector_power_enable,
  output logic                   detector_reset_enable,
  output logic                   detector_stop_enable,
  output logic                   detector_active,
  output logic                   detector_reset_req,
  output logic                   short_stop_recovery,
  output logic [12:0]            stop_recovery_cycles,
  output logic                   watchdog_short_timeout,
  output logic [17:0]            watchdog_timeout_cycles,
  output logic                   watchdog_disable,
  output logic                   watchdog_enable,
  output logic                   stop_enable,
  output logic                   stop_illegal,
  output logic                   can_disable,
  output logic                   eeprom_timebase_clock_select,
  output logic                   emulator_config_select,
  output logic                   version_indicator
);
  import wooc_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic [1:0] wooc_sel(input logic [ADDR_W-1:0] a);
    if (a == WOOC_SYS_OFS[ADDR_W-1:0]) begin
      return WOOC_SEL_SYS;
    end else if (a == WOOC_DEV_OFS[ADDR_W-1:0]) begin
      return WOOC_SEL_DEV;
    end else begin
      return WOOC_SEL_NONE;
    end
  endfunction

  wooc_regs_t q;
  wooc_regs_t d;
  logic       emu_q;
  logic       trip_hold;
  logic [1:0] sel;
  logic       setup;
  logic       wr_acc;
  logic       wr_sys_first;
  logic       wr_dev_first;

  assign sel          = wooc_sel(paddr);
  assign setup        = psel && !penable;
  // Zero wait states: every access phase completes at once
  assign wr_acc       = psel && penable && pwrite;
  assign wr_sys_first = wr_acc && (sel == WOOC_SEL_SYS) && !q.sys_lock;
  assign wr_dev_first = wr_acc && (sel == WOOC_SEL_DEV) && !q.dev_lock;

  // ****************************************************************
  // Register state
  // ****************************************************************
  always_comb begin
    d = q;
    if (setup) begin
      // Read data is taken in setup so the access phase sees a flop
      d.err   = (sel == WOOC_SEL_NONE);
      d.rdata = 32'h0000_0000;
      if (!pwrite && sel == WOOC_SEL_SYS) begin
        d.rdata[6:0] = q.sys;
      end else if (!pwrite && sel == WOOC_SEL_DEV) begin
        d.rdata[WOOC_DEV_CAN_DIS] = q.dev[WOOC_DEV_CAN_DIS];
        d.rdata[WOOC_DEV_EE_CLK]  = q.dev[WOOC_DEV_EE_CLK];
        d.rdata[WOOC_DEV_EMU]     = emu_q;
        d.rdata[WOOC_DEV_VERSION] = VERSION_BIT;
      end
    end
    if (wr_sys_first) begin
      d.sys      = pwdata[6:0];
      d.sys_lock = 1'b1;
    end
    if (wr_dev_first) begin
      d.dev      = pwdata[1:0];
      d.dev_lock = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= WOOC_REGS_RST;
    end else begin
      q <= d;
    end
  end

  // Survives ordinary resets; only power-on clears it
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      emu_q <= WOOC_EMU_RST;
    end else if (wr_dev_first) begin
      emu_q <= pwdata[WOOC_DEV_EMU];
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  assign pready  = 1'b1;
  assign prdata  = q.rdata;
  assign pslverr = psel && penable && q.err;

  // ****************************************************************
  // Option outputs
  // ****************************************************************
  assign watchdog_disable       = q.sys[WOOC_SYS_WDOG_DIS];
  assign watchdog_enable        = !q.sys[WOOC_SYS_WDOG_DIS];
  assign stop_enable            = q.sys[WOOC_SYS_STOP_EN];
  assign stop_illegal           = !q.sys[WOOC_SYS_STOP_EN];
  assign watchdog_short_timeout = q.sys[WOOC_SYS_WDOG_SHRT];
  assign short_stop_recovery    = q.sys[WOOC_SYS_SHORT_REC];
  assign detector_power_enable  = q.sys[WOOC_SYS_LVD_PWR];
  assign detector_reset_enable  = q.sys[WOOC_SYS_LVD_RST];
  assign detector_stop_enable   = q.sys[WOOC_SYS_LVD_STOP];
  assign can_disable            = q.dev[WOOC_DEV_CAN_DIS];
  assign eeprom_timebase_clock_select = q.dev[WOOC_DEV_EE_CLK];
  assign emulator_config_select = emu_q;
  assign version_indicator      = VERSION_BIT;

  // Short recovery is unsafe with a slow-starting external crystal
  assign stop_recovery_cycles = short_stop_recovery ?
                                WOOC_STOP_REC_SHORT : WOOC_STOP_REC_LONG;
  assign watchdog_timeout_cycles = watchdog_short_timeout ?
                                   WDOG_SHORT : WDOG_LONG;

  // Power off kills it; in stop mode it also needs the stop enable
  assign detector_active = detector_power_enable &&
                           (!stop_mode || detector_stop_enable);
  assign detector_reset_req = trip_hold && detector_reset_enable
                              && detector_power_enable;

  wooc_lvd_filter #(
    .PERSIST (WOOC_LVD_PERSIST)
  ) u_lvd_filter (
    .pclk                  (pclk),
    .presetn               (presetn),
    .active                (detector_active),
    .low_supply_trip       (low_supply_trip),
    .supply_recovered_trip (supply_recovered_trip),
    .trip_hold             (trip_hold)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sys_write_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.sys_lock |=> $stable(q.sys) && q.sys_lock)
    else $error("system options changed after lock");

  a_first_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sys_first |=> (q.sys == $past(pwdata[6:0])) && q.sys_lock)
    else $error("first system write not stored");

  a_default_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel == WOOC_SEL_SYS && !q.sys_lock)
    |=> prdata == {25'h0, WOOC_SYS_RST})
    else $error("default not returned before first write");

  a_detector_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stop_mode && !(detector_power_enable && detector_stop_enable))
    |-> !detector_active)
    else $error("detector active in stop without both enables");

  a_reset_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (detector_reset_enable && detector_power_enable &&
     low_supply_trip && detector_active && !supply_recovered_trip)[*8]
    ##1 (low_supply_trip && detector_active && !supply_recovered_trip)
    |=> detector_reset_req)
    else $error("enabled detector reset not raised");

  a_outputs_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sys_first |=> stop_illegal == !$past(pwdata[WOOC_SYS_STOP_EN]) &&
      watchdog_enable == !$past(pwdata[WOOC_SYS_WDOG_DIS]))
    else $error("option outputs do not follow stored value");

  a_recovery_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sys_first |=> stop_recovery_cycles ==
      ($past(pwdata[WOOC_SYS_SHORT_REC]) ? 13'h0020 : 13'h1000))
    else $error("stop recovery length wrong");

  a_version_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel == WOOC_SEL_DEV)
    |=> prdata[WOOC_DEV_VERSION] == VERSION_BIT)
    else $error("version indicator not read back");

  a_dev_write_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.dev_lock |=> $stable(can_disable) && $stable(emulator_config_select))
    else $error("device options changed after lock");
endmodule

`default_nettype wire

// *** rtl/wooc_lvd_filter.sv ***
// Low-supply persistence filter with hold until supply recovery
`timescale 1ns/1ps
`default_nettype none

module wooc_lvd_filter #(
  parameter int unsigned PERSIST = wooc_pkg::WOOC_LVD_PERSIST
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic active,
  input  wire logic low_supply_trip,
  input  wire logic supply_recovered_trip,
  output logic      trip_hold
);
  import wooc_pkg::*;

  localparam int unsigned CW = $clog2(PERSIST + 1);

  typedef struct packed {
    wooc_lvd_state_t state;
    logic [CW-1:0]   cnt;
  } wooc_filt_t;

  wooc_filt_t q;
  wooc_filt_t d;

  // ****************************************************************
  // Filter state
  // ****************************************************************
  always_comb begin
    d = q;
    case (q.state)
      WOOC_LVD_IDLE: begin
        d.cnt = '0;
        if (active && low_supply_trip) begin
          d.state = (PERSIST <= 1) ? WOOC_LVD_HELD : WOOC_LVD_COUNT;
          d.cnt   = CW'(1);
        end
      end
      WOOC_LVD_COUNT: begin
        // A single sample without the low trip, or while inactive, restarts the count
        if (!active || !low_supply_trip) begin
          d.state = WOOC_LVD_IDLE;
          d.cnt   = '0;
        end else if (q.cnt == CW'(PERSIST - 1)) begin
          d.state = WOOC_LVD_HELD;
        end else begin
          d.cnt = q.cnt + CW'(1);
        end
      end
      WOOC_LVD_HELD: begin
        if (supply_recovered_trip) begin
          d.state = WOOC_LVD_IDLE;
          d.cnt   = '0;
        end
      end
      default: begin
        d.state = WOOC_LVD_IDLE;
        d.cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{state: WOOC_LVD_IDLE, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign trip_hold = (q.state == WOOC_LVD_HELD);

  a_nine_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active && low_supply_trip && !supply_recovered_trip)[*8]
    ##1 (active && low_supply_trip && !supply_recovered_trip)
    |=> trip_hold)
    else $error("hold not raised after nine low cycles");

  a_hold_until: assert property (
    @(posedge pclk) disable iff (!presetn)
    (trip_hold && !supply_recovered_trip) |=> trip_hold)
    else $error("hold dropped before supply recovery");

  a_no_early: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!trip_hold && !low_supply_trip) |=> !trip_hold [*8])
    else $error("hold raised in under nine low cycles");
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the write-once option register bank
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
  import wooc_pkg::*;
  localparam logic        VER   = 1'b1;
  localparam logic [11:0] A_SYS = WOOC_SYS_OFS[11:0];
  localparam logic [11:0] A_DEV = WOOC_DEV_OFS[11:0];
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        por_n     = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0;
  logic        stop_mode = 1'b0;
  logic        low_trip  = 1'b0;
  logic        rec_trip  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwr_en, rst_en, stp_en, det_act, det_req, ssr, wd_sh;
  logic        wd_dis, wd_en, stop_en, stop_ill, can_dis, ee_sel, emu, ver;
  logic [12:0] rec_cyc;
  logic [17:0] wd_cyc;
  int          fails   = 0;
  int          n_tests = 0;
  int          cyc     = 0;

  wooc_option_config #(.ADDR_W(12), .VERSION_BIT(VER)) uut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .low_supply_trip(low_trip),
    .supply_recovered_trip(rec_trip), .detector_power_enable(pwr_en),
    .detector_reset_enable(rst_en), .detector_stop_enable(stp_en),
    .detector_active(det_act), .detector_reset_req(det_req),
    .short_stop_recovery(ssr), .stop_recovery_cycles(rec_cyc),
    .watchdog_short_timeout(wd_sh), .watchdog_timeout_cycles(wd_cyc),
    .watchdog_disable(wd_dis), .watchdog_enable(wd_en),
    .stop_enable(stop_en), .stop_illegal(stop_ill), .can_disable(can_dis),
    .eeprom_timebase_clock_select(ee_sel), .emulator_config_select(emu),
    .version_indicator(ver)
  );

  always #5 pclk = ~pclk;

  task automatic stop_test;
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-bit compare, widened on purpose
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic rst(input logic por);
    presetn <= 1'b0;
    if (por) por_n <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    @(posedge pclk);
  endtask

  // Master waits on pready with no assumed latency; idle cycle follows
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                     input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk1(e, experr);
  endtask

  task automatic outs(input logic [6:0] s);
    chk1(wd_dis, s[0]);
    chk1(wd_en, !s[0]);
    chk1(stop_en, s[1]);
    chk1(stop_ill, !s[1]);
    chk1(wd_sh, s[2]);
    chk({14'h0, wd_cyc},
        s[2] ? 32'h2000 - 32'h10 : 32'h40000 - 32'h10);
    chk1(ssr, s[3]);
    chk({19'h0, rec_cyc}, s[3] ? 32'h20 : 32'h1000);
    chk1(pwr_en, s[4]);
    chk1(rst_en, s[5]);
    chk1(stp_en, s[6]);
  endtask

  task automatic trip(input int n);
    low_trip <= 1'b1;
    repeat (n) @(posedge pclk);
    low_trip <= 1'b0;
  endtask

  task automatic t_defaults;
    rdc(A_SYS, 32'h0, 1'b0);
    rdc(A_DEV, {24'h0, VER, 7'h00}, 1'b0);
    outs(7'h00);
    chk1(can_dis, 1'b0);
    chk1(ee_sel, 1'b0);
    chk1(emu, 1'b0);
    wr(12'h008, 8'hff);
    rdc(12'h008, 32'h0, 1'b1);
    rdc(A_SYS, 32'h0, 1'b0);
    trip(10);
    @(posedge pclk);
    chk1(det_req, 1'b0);
    chk1(det_act, 1'b0);
  endtask

  task automatic t_blocked;
    wr(A_SYS, 8'h10);
    outs(7'h10);
    chk1(det_act, 1'b1);
    stop_mode <= 1'b1;
    @(posedge pclk);
    chk1(det_act, 1'b0);
    stop_mode <= 1'b0;
    trip(10);
    @(posedge pclk);
    chk1(det_req, 1'b0);
  endtask

  task automatic t_once;
    // Bench clock stands for an internal oscillator, so short recovery is ok
    wr(A_SYS, 8'h7f);
    wr(A_SYS, 8'h00);
    rdc(A_SYS, 32'h7f, 1'b0);
    outs(7'h7f);
    stop_mode <= 1'b1;
    @(posedge pclk);
    chk1(det_act, 1'b1);
    stop_mode <= 1'b0;
    trip(8);
    repeat (3) @(posedge pclk);
    chk1(det_req, 1'b0);
    trip(9);
    @(posedge pclk);
    chk1(det_req, 1'b1);
    repeat (4) @(posedge pclk);
    chk1(det_req, 1'b1);
    rec_trip <= 1'b1;
    @(posedge pclk);
    chk1(det_req, 1'b1);
    @(posedge pclk);
    chk1(det_req, 1'b0);
    rec_trip <= 1'b0;
  endtask

  task automatic t_dev;
    wr(A_DEV, 8'h07);
    wr(A_DEV, 8'h00);
    rdc(A_DEV, {24'h0, VER, 7'h07}, 1'b0);
    chk1(can_dis, 1'b1);
    chk1(ee_sel, 1'b1);
    chk1(emu, 1'b1);
    chk1(ver, VER);
  endtask

  task automatic t_resets;
    rst(1'b0);
    rdc(A_DEV, {24'h0, VER, 7'h04}, 1'b0);
    rdc(A_SYS, 32'h0, 1'b0);
    outs(7'h00);
    rst(1'b1);
    chk1(emu, 1'b0);
    rdc(A_DEV, {24'h0, VER, 7'h00}, 1'b0);
  endtask

  initial begin
    @(posedge pclk);
    rst(1'b1);
    t_defaults;
    t_blocked;
    rst(1'b0);
    t_once;
    t_dev;
    t_resets;
    stop_test;
  end
endmodule

`default_nettype wire
